// file: dac_i2c_pkg.sv
// Purpose: shared constants, types and state layout for the quad dac i2c update logic
// Assumes: one system clock plus the bus clock as a second domain
// Notes: control byte field positions and load mode codes below

package dac_i2c_pkg;

  localparam int NUM_CH = 4;
  localparam logic [4:0] ADDR_FIXED = 5'h13;
  localparam logic [7:0] BCAST_ADDR = 8'h90;
  localparam logic [4:0] HS_CODE_TOP = 5'h01;
  localparam logic [3:0] BIT_FULL = 4'h8;
  localparam logic [3:0] BIT_ZERO = 4'h0;
  localparam logic [1:0] STRAP_DELAY = 2'h3;

  // control byte and msb byte field positions
  localparam int CB_EXT_HI = 7;
  localparam int CB_EXT_LO = 6;
  localparam int CB_LOAD_HI = 5;
  localparam int CB_LOAD_LO = 4;
  localparam int CB_SEL_HI = 2;
  localparam int CB_SEL_LO = 1;
  localparam int CB_PD = 0;
  localparam int MSB_PD_HI = 7;
  localparam int MSB_PD_LO = 6;

  localparam logic [1:0] LOAD_STAGE = 2'h0;
  localparam logic [1:0] LOAD_BOTH = 2'h1;
  localparam logic [1:0] LOAD_SYNC = 2'h2;
  localparam logic [1:0] LOAD_BCAST = 2'h3;

  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [9:0] WORD_RESET = 10'h000;
  localparam logic [7:0] PD_DATA_FILL = 8'h00;
  localparam logic [1:0] PD_NONE = 2'h0;

  typedef enum logic [2:0] {PH_IDLE, PH_ADDR, PH_CTRL, PH_MSB, PH_LSB, PH_SKIP} phase_t;

  typedef logic [9:0] chan_word_t;
  typedef chan_word_t [NUM_CH-1:0] quad_t;

  // pin levels carried together through the synchroniser
  typedef struct packed {
    logic load;
    logic ext_hi;
    logic ext_lo;
    logic dev_hi;
    logic dev_lo;
  } pins_t;

  // bus clock domain state
  typedef struct packed {
    logic tgl;
    logic bitv;
  } link_t;

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_s3;
    logic sda_s1;
    logic sda_s2;
    logic sda_s3;
    logic tgl_s1;
    logic tgl_s2;
    logic tgl_s3;
    logic tgl_s4;
    logic bitv_s1;
    logic bitv_s2;
    pins_t pins_s1;
    pins_t pins_s2;
    logic load_prev;
    logic link_rst;
    logic [1:0] strap_cnt;
    logic strap_taken;
    logic [1:0] dev_pins;
    phase_t phase;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic ack_due;
    logic upd_due;
    logic sda_oe_n;
    logic sda_o;
    logic hs_mode;
    logic [7:0] ctrl;
    logic [7:0] msb;
    quad_t staging;
    quad_t outreg;
  } state_t;

endpackage : dac_i2c_pkg

// file: quad_dac_i2c_update_logic.sv
// Purpose: i2c slave write path and register update logic of a quad 8-bit dac
// Assumes: clk much faster than the bus clock; sda and pins arrive asynchronously
// Notes: bits are captured on the bus clock, conditions are found by oversampling
`timescale 1ns/10ps

module quad_dac_i2c_update_logic
  import dac_i2c_pkg::*;
(
  // system
  input wire logic clk,
  input wire logic sys_rst,
  // i2c bus
  input wire logic scl_clk,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  // address select and load pins
  input wire logic device_pin_hi,
  input wire logic device_pin_lo,
  input wire logic extended_pin_hi,
  input wire logic extended_pin_lo,
  input wire logic hardware_load_input,
  // register contents
  output quad_t output_word,
  output quad_t staging_word,
  output logic hs_mode
);

  state_t q;
  state_t d;
  link_t lq;
  logic link_rst;

  //--------------------------------------------------------------
  // bus clock domain
  //--------------------------------------------------------------
  // reset is applied asynchronously since the bus clock may stand still
  always_ff @(posedge scl_clk or posedge link_rst) begin
    if (link_rst) begin
      lq <= '0;
    end else begin
      lq.tgl <= ~lq.tgl;
      lq.bitv <= sda_i;
    end
  end

  //--------------------------------------------------------------
  // update decode
  //--------------------------------------------------------------
  function automatic chan_word_t rx_word(input logic [7:0] ctrl, input logic [7:0] msb);
    chan_word_t w;
    w = {PD_NONE, msb};
    if (ctrl[CB_PD]) begin
      w = {msb[MSB_PD_HI:MSB_PD_LO], PD_DATA_FILL};
    end
    return w;
  endfunction : rx_word

  function automatic state_t apply_update(input state_t s, input logic ext_match);
    state_t r;
    chan_word_t w;
    logic [1:0] mode;
    logic [1:0] sel;
    r = s;
    w = rx_word(s.ctrl, s.msb);
    mode = s.ctrl[CB_LOAD_HI:CB_LOAD_LO];
    sel = s.ctrl[CB_SEL_HI:CB_SEL_LO];
    // pin match comes from the caller so only the second synchroniser stage is read
    if (mode == LOAD_BCAST || ext_match) begin
      case (mode)
        LOAD_STAGE: begin
          r.staging[sel] = w;
        end
        LOAD_BOTH: begin
          r.staging[sel] = w;
          r.outreg[sel] = w;
        end
        LOAD_SYNC: begin
          for (int i = 0; i < NUM_CH; i++) begin
            r.outreg[i] = s.staging[i];
          end
          r.staging[sel] = w;
          r.outreg[sel] = w;
        end
        LOAD_BCAST: begin
          for (int i = 0; i < NUM_CH; i++) begin
            r.outreg[i] = s.ctrl[CB_SEL_HI] ? w : s.staging[i];
          end
        end
        default: begin
          r = s;
        end
      endcase
    end
    return r;
  endfunction : apply_update

  //--------------------------------------------------------------
  // bus events seen in the system domain
  //--------------------------------------------------------------
  logic start_seen;
  logic stop_seen;
  logic scl_fall;
  logic bit_in;
  logic byte_fire;
  logic [7:0] byte_val;
  logic load_edge;
  logic upd_fire;
  logic addr_match;
  logic ext_ok;
  logic [1:0] sel_now;
  chan_word_t rx_now;
  quad_t rx_all;

  assign start_seen = q.scl_s2 && q.scl_s3 && q.sda_s3 && !q.sda_s2;
  assign stop_seen = q.scl_s2 && q.scl_s3 && !q.sda_s3 && q.sda_s2;
  assign scl_fall = q.scl_s3 && !q.scl_s2;
  // the bit value settles a cycle before the delayed toggle edge is used
  assign bit_in = q.tgl_s3 != q.tgl_s4;
  assign byte_fire = bit_in && q.bit_cnt == BIT_FULL - 4'h1;
  assign byte_val = {q.shift[6:0], q.bitv_s2};
  assign load_edge = q.pins_s2.load && !q.load_prev;
  assign upd_fire = scl_fall && !q.sda_oe_n && q.bit_cnt == BIT_ZERO && q.upd_due;
  assign addr_match = byte_val == {ADDR_FIXED, q.dev_pins, 1'b0};
  assign ext_ok = q.ctrl[CB_EXT_HI:CB_EXT_LO] == {q.pins_s2.ext_hi, q.pins_s2.ext_lo};
  assign sel_now = q.ctrl[CB_SEL_HI:CB_SEL_LO];
  assign rx_now = rx_word(q.ctrl, q.msb);
  assign rx_all = {NUM_CH{rx_now}};

  //--------------------------------------------------------------
  // next state
  //--------------------------------------------------------------
  always_comb begin
    d = q;
    d.scl_s1 = scl_clk;
    d.scl_s2 = q.scl_s1;
    d.scl_s3 = q.scl_s2;
    d.sda_s1 = sda_i;
    d.sda_s2 = q.sda_s1;
    d.sda_s3 = q.sda_s2;
    d.tgl_s1 = lq.tgl;
    d.tgl_s2 = q.tgl_s1;
    d.tgl_s3 = q.tgl_s2;
    d.tgl_s4 = q.tgl_s3;
    d.bitv_s1 = lq.bitv;
    d.bitv_s2 = q.bitv_s1;
    d.pins_s1 = '{load: hardware_load_input, ext_hi: extended_pin_hi,
                  ext_lo: extended_pin_lo, dev_hi: device_pin_hi, dev_lo: device_pin_lo};
    d.pins_s2 = q.pins_s1;
    d.load_prev = q.pins_s2.load;
    d.link_rst = 1'b0;
    d.sda_o = 1'b0;

    // select pins are latched once, after the synchroniser has filled
    if (!q.strap_taken) begin
      if (q.strap_cnt == STRAP_DELAY) begin
        d.strap_taken = 1'b1;
        d.dev_pins = {q.pins_s2.dev_hi, q.pins_s2.dev_lo};
      end else begin
        d.strap_cnt = q.strap_cnt + 2'h1;
      end
    end

    if (load_edge) begin
      for (int i = 0; i < NUM_CH; i++) begin
        d.outreg[i] = q.staging[i];
      end
    end

    // bit shifting and byte decode
    if (bit_in && q.phase != PH_IDLE) begin
      if (q.bit_cnt == BIT_FULL) begin
        d.bit_cnt = BIT_ZERO;
      end else begin
        d.bit_cnt = q.bit_cnt + 4'h1;
        d.shift = byte_val;
      end
      if (byte_fire) begin
        case (q.phase)
          PH_ADDR: begin
            if (byte_val[7:3] == HS_CODE_TOP && !q.hs_mode) begin
              d.hs_mode = 1'b1;
              d.phase = PH_SKIP;
            end else if (addr_match || byte_val == BCAST_ADDR) begin
              d.ack_due = 1'b1;
              d.phase = PH_CTRL;
            end else begin
              d.phase = PH_SKIP;
            end
          end
          PH_CTRL: begin
            d.ctrl = byte_val;
            d.ack_due = 1'b1;
            d.phase = PH_MSB;
          end
          PH_MSB: begin
            d.msb = byte_val;
            d.ack_due = 1'b1;
            d.phase = PH_LSB;
          end
          PH_LSB: begin
            // lsb content is never stored, only its arrival counts
            d.ack_due = 1'b1;
            d.upd_due = 1'b1;
            d.phase = PH_MSB;
          end
          default: begin
            d.phase = q.phase;
          end
        endcase
      end
    end

    // ack drive from the eighth falling edge to the ninth
    if (scl_fall) begin
      if (q.ack_due && q.bit_cnt == BIT_FULL) begin
        d.sda_oe_n = 1'b0;
        d.ack_due = 1'b0;
      end else if (!q.sda_oe_n && q.bit_cnt == BIT_ZERO) begin
        d.sda_oe_n = 1'b1;
        d.upd_due = 1'b0;
        if (q.upd_due) begin
          d = apply_update(d, ext_ok);
        end
      end
    end

    // conditions override the byte flow; a half-done pair is dropped
    if (start_seen) begin
      d.phase = PH_ADDR;
      d.bit_cnt = BIT_ZERO;
      d.ack_due = 1'b0;
      d.upd_due = 1'b0;
      d.sda_oe_n = 1'b1;
    end else if (stop_seen) begin
      d.phase = PH_IDLE;
      d.bit_cnt = BIT_ZERO;
      d.ack_due = 1'b0;
      d.upd_due = 1'b0;
      d.sda_oe_n = 1'b1;
      d.hs_mode = 1'b0;
    end

    if (sys_rst) begin
      d = '0;
      d.phase = PH_IDLE;
      d.sda_oe_n = 1'b1;
      d.link_rst = 1'b1;
      // bus lines idle high, so the edge finders start from that level
      d.scl_s1 = 1'b1;
      d.scl_s2 = 1'b1;
      d.scl_s3 = 1'b1;
      d.sda_s1 = 1'b1;
      d.sda_s2 = 1'b1;
      d.sda_s3 = 1'b1;
      d.ctrl = BYTE_RESET;
      d.msb = BYTE_RESET;
      d.staging = {NUM_CH{WORD_RESET}};
      d.outreg = {NUM_CH{WORD_RESET}};
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  assign sda_o = q.sda_o;
  assign sda_oe_n = q.sda_oe_n;
  assign output_word = q.outreg;
  assign staging_word = q.staging;
  assign hs_mode = q.hs_mode;
  assign link_rst = q.link_rst;

  //--------------------------------------------------------------
  // checks
  //--------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_hs_enter: assert property (byte_fire && q.phase == PH_ADDR && !q.hs_mode
      && byte_val[7:3] == HS_CODE_TOP && !start_seen && !stop_seen
      |=> q.hs_mode && !q.ack_due && q.phase == PH_SKIP)
    else $error("master code not taken as high-speed entry");
  a_hs_leave: assert property (stop_seen |=> !q.hs_mode && q.phase == PH_IDLE)
    else $error("stop did not leave high-speed mode");
  a_hs_keep: assert property (start_seen && q.hs_mode |=> q.hs_mode)
    else $error("repeated start left high-speed mode");
  a_ack_drive: assert property (q.ack_due && scl_fall && q.bit_cnt == BIT_FULL
      && !start_seen && !stop_seen |=> !q.sda_oe_n)
    else $error("ack not driven after eighth bit");
  a_ack_release: assert property (!q.sda_oe_n && scl_fall && q.bit_cnt == BIT_ZERO
      |=> q.sda_oe_n)
    else $error("ack held past ninth clock");
  a_stop_idle: assert property (stop_seen |=> q.sda_oe_n && !q.ack_due && !q.upd_due)
    else $error("bus not released after stop");
  a_strap_hold: assert property (q.strap_taken |=> q.strap_taken && $stable(q.dev_pins))
    else $error("captured select pins changed");
  a_foreign_addr: assert property (byte_fire && q.phase == PH_ADDR
      && byte_val[7:4] != ADDR_FIXED[4:1] |=> !q.ack_due)
    else $error("foreign address acknowledged");
  a_bcast_addr: assert property (byte_fire && q.phase == PH_ADDR && byte_val == BCAST_ADDR
      && !start_seen && !stop_seen |=> q.ack_due && q.phase == PH_CTRL)
    else $error("broadcast address not acknowledged");
  a_stage_only: assert property (upd_fire && !load_edge
      && q.ctrl[CB_LOAD_HI:CB_LOAD_LO] == LOAD_STAGE |=> $stable(q.outreg))
    else $error("staging-only load changed outputs");
  a_stage_value: assert property (upd_fire && ext_ok
      && q.ctrl[CB_LOAD_HI:CB_LOAD_LO] == LOAD_STAGE |=> q.staging[sel_now] == $past(rx_now))
    else $error("staging register missed the received word");
  a_both_load: assert property (upd_fire && ext_ok
      && q.ctrl[CB_LOAD_HI:CB_LOAD_LO] == LOAD_BOTH
      |=> q.staging[sel_now] == $past(rx_now) && q.outreg[sel_now] == $past(rx_now))
    else $error("direct load missed the chosen channel");
  a_sync_load: assert property (upd_fire && ext_ok
      && q.ctrl[CB_LOAD_HI:CB_LOAD_LO] == LOAD_SYNC
      |=> q.staging[sel_now] == $past(rx_now) && q.outreg == q.staging)
    else $error("synchronous load left outputs apart from staging");
  a_bcast_copy: assert property (upd_fire && !q.ctrl[CB_SEL_HI]
      && q.ctrl[CB_LOAD_HI:CB_LOAD_LO] == LOAD_BCAST |=> q.outreg == $past(q.staging))
    else $error("broadcast copy did not move staging to outputs");
  a_bcast_value: assert property (upd_fire && q.ctrl[CB_SEL_HI]
      && q.ctrl[CB_LOAD_HI:CB_LOAD_LO] == LOAD_BCAST |=> q.outreg == $past(rx_all))
    else $error("broadcast value not loaded into every output");
  a_ext_gate: assert property (upd_fire && !load_edge
      && q.ctrl[CB_LOAD_HI:CB_LOAD_LO] != LOAD_BCAST
      && q.ctrl[CB_EXT_HI:CB_EXT_LO] != {q.pins_s2.ext_hi, q.pins_s2.ext_lo}
      |=> $stable(q.outreg) && $stable(q.staging))
    else $error("update despite extended pin mismatch");
  a_load_copy: assert property (load_edge && !upd_fire |=> q.outreg == $past(q.staging))
    else $error("load input did not copy staging");
  a_pair_drop: assert property (start_seen |=> !q.upd_due && q.phase == PH_ADDR)
    else $error("partial pair survived a start");

  c_hs_entry: cover property (byte_fire && q.phase == PH_ADDR && byte_val[7:3] == HS_CODE_TOP);
  c_update: cover property (upd_fire);
  c_load: cover property (load_edge);
  c_pair_cut: cover property (stop_seen && q.phase == PH_LSB);
  c_sync_update: cover property (upd_fire && q.ctrl[CB_LOAD_HI:CB_LOAD_LO] == LOAD_SYNC);

endmodule : quad_dac_i2c_update_logic

// file: i2c_master_model.sv
// Purpose: behavioural i2c bus master that writes to the dac update logic
// Assumes: open-drain bus with pull-up; sda_pull high means the master pulls sda low
// Notes: scl stands high between frames; phases are 96 ns so the slave's oversampling keeps up
`timescale 1ns/10ps

module i2c_master_model (
  // bus clock and master's sda drive
  output logic scl_clk,
  output logic sda_pull,
  // resolved sda wire
  input wire logic sda_bus
);
  localparam int HALF = 96;

  initial begin
    scl_clk = 1'b1;
    sda_pull = 1'b0;
  end

  // ----------------------------------------
  // bus conditions
  // ----------------------------------------
  // from idle this is a start; from scl low it is a repeated start
  task automatic start_cond();
    sda_pull = 1'b0;
    #(HALF) scl_clk = 1'b1;
    #(HALF) sda_pull = 1'b1;
    #(HALF) scl_clk = 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    #(HALF/2) sda_pull = 1'b1;
    #(HALF/2) scl_clk = 1'b1;
    #(HALF) sda_pull = 1'b0;
    #(HALF);
  endtask : stop_cond

  // data only changes while scl is low; ack is sampled mid high phase
  task automatic send_byte(input logic [7:0] b, output logic ack);
    int i;
    for (i = 7; i >= 0; i--) begin
      #(HALF/2) sda_pull = ~b[i];
      #(HALF/2) scl_clk = 1'b1;
      #(HALF) scl_clk = 1'b0;
    end
    #(HALF/2) sda_pull = 1'b0;
    #(HALF/2) scl_clk = 1'b1;
    #(HALF/2) ack = ~sda_bus;
    #(HALF/2) scl_clk = 1'b0;
  endtask : send_byte
endmodule : i2c_master_model

// file: quad_dac_i2c_update_logic_tb_top.sv
// Purpose: self-checking bench for the quad dac i2c update logic
// Assumes: select pins 10 at power-up, extended pins 01
// Notes: expected register words are predicted from the control byte fields
`timescale 1ns/10ps

module quad_dac_i2c_update_logic_tb_top;
  import dac_i2c_pkg::*;

  localparam logic [7:0] ADDR = {ADDR_FIXED, 2'h2, 1'b0};
  localparam logic [7:0] EXT = 8'h40;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic scl_clk, sda_pull, sda_bus, sda_o, sda_oe_n, hs_mode;
  logic device_pin_hi = 1'b1;
  logic device_pin_lo = 1'b0;
  logic extended_pin_hi = 1'b0;
  logic extended_pin_lo = 1'b1;
  logic hardware_load_input = 1'b0;
  quad_t output_word, staging_word, exp_out, exp_stg;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic ack;

  always #5 clk = ~clk;
  assign sda_bus = sda_pull ? 1'b0 : ((sda_oe_n === 1'b0) ? sda_o : 1'b1);

  i2c_master_model i2c_master_model_inst (.scl_clk(scl_clk), .sda_pull(sda_pull),
    .sda_bus(sda_bus));

  quad_dac_i2c_update_logic quad_dac_i2c_update_logic_inst (.clk(clk), .sys_rst(sys_rst),
    .scl_clk(scl_clk), .sda_i(sda_bus), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .device_pin_hi(device_pin_hi), .device_pin_lo(device_pin_lo),
    .extended_pin_hi(extended_pin_hi), .extended_pin_lo(extended_pin_lo),
    .hardware_load_input(hardware_load_input), .output_word(output_word),
    .staging_word(staging_word), .hs_mode(hs_mode));

  // ----------------------------------------
  // checking
  // ----------------------------------------
  task automatic print_verdict();
    $display("checked %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  task automatic cmp_quad(input quad_t got, input quad_t exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_quad

  task automatic cmp_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_bit

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      err_total++;
      print_verdict();
    end
  end

  // reference behaviour of one completed byte pair
  function automatic void predict(input logic [7:0] c, input logic [7:0] d);
    chan_word_t w;
    logic [1:0] sel;
    w = c[CB_PD] ? {d[MSB_PD_HI:MSB_PD_LO], 8'h00} : {2'h0, d};
    sel = c[CB_SEL_HI:CB_SEL_LO];
    if (c[CB_LOAD_HI:CB_LOAD_LO] != 2'h3 && c[7:6] != EXT[7:6]) return;
    case (c[CB_LOAD_HI:CB_LOAD_LO])
      2'h0: exp_stg[sel] = w;
      2'h1: begin
        exp_stg[sel] = w;
        exp_out[sel] = w;
      end
      2'h2: begin
        exp_stg[sel] = w;
        exp_out = exp_stg;
      end
      default: exp_out = c[CB_SEL_HI] ? {NUM_CH{w}} : exp_stg;
    endcase
  endfunction : predict

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic xfer(input logic [7:0] a, input logic [7:0] c, input logic [7:0] d,
                      input int n, input bit fin);
    int i;
    i2c_master_model_inst.start_cond();
    i2c_master_model_inst.send_byte(a, ack);
    cmp_bit(ack, 1'b1);
    i2c_master_model_inst.send_byte(c, ack);
    cmp_bit(ack, 1'b1);
    for (i = 0; i < n; i++) begin
      i2c_master_model_inst.send_byte(d + 8'(i), ack);
      cmp_bit(ack, 1'b1);
      i2c_master_model_inst.send_byte(8'hA5, ack);
      cmp_bit(ack, 1'b1);
      cmp_quad(output_word, exp_out);
      predict(c, d + 8'(i));
      #100;
      cmp_quad(output_word, exp_out);
      cmp_quad(staging_word, exp_stg);
    end
    if (fin) i2c_master_model_inst.stop_cond();
  endtask : xfer

  // refused address: nothing after it may take effect
  task automatic noack(input logic [7:0] a);
    i2c_master_model_inst.start_cond();
    i2c_master_model_inst.send_byte(a, ack);
    cmp_bit(ack, 1'b0);
    i2c_master_model_inst.send_byte(EXT | 8'h10, ack);
    i2c_master_model_inst.send_byte(8'h33, ack);
    i2c_master_model_inst.send_byte(8'h00, ack);
    i2c_master_model_inst.stop_cond();
    #100;
    cmp_quad(output_word, exp_out);
  endtask : noack

  task automatic t_partial();
    i2c_master_model_inst.start_cond();
    i2c_master_model_inst.send_byte(ADDR, ack);
    i2c_master_model_inst.send_byte(EXT | 8'h10, ack);
    i2c_master_model_inst.send_byte(8'h44, ack);
    i2c_master_model_inst.stop_cond();
    #100;
    cmp_quad(output_word, exp_out);
    cmp_quad(staging_word, exp_stg);
  endtask : t_partial

  task automatic t_hs();
    i2c_master_model_inst.start_cond();
    i2c_master_model_inst.send_byte(8'h0B, ack);
    cmp_bit(ack, 1'b0);
    #100;
    cmp_bit(hs_mode, 1'b1);
    xfer(ADDR, EXT | 8'h12, 8'h61, 1, 1'b0);
    cmp_bit(hs_mode, 1'b1);
    i2c_master_model_inst.stop_cond();
    #100;
    cmp_bit(hs_mode, 1'b0);
  endtask : t_hs

  task automatic t_hwload();
    xfer(ADDR, EXT | 8'h06, 8'h5A, 1, 1'b1);
    @(posedge clk) #1 hardware_load_input = 1'b1;
    repeat (6) @(posedge clk);
    #1 hardware_load_input = 1'b0;
    exp_out = exp_stg;
    #100;
    cmp_quad(output_word, exp_out);
  endtask : t_hwload

  initial begin
    int s;
    exp_out = '0;
    exp_stg = '0;
    repeat (2) @(posedge clk);
    #1 sys_rst = 1'b0;
    repeat (12) @(posedge clk);
    #1;
    cmp_quad(output_word, '0);
    cmp_quad(staging_word, '0);
    cmp_bit(hs_mode, 1'b0);
    device_pin_hi = 1'b0;
    device_pin_lo = 1'b1;
    for (s = 0; s < NUM_CH; s++) xfer(ADDR, EXT | 8'(s * 2), 8'h10 + 8'(s), 1, 1'b1);
    xfer(ADDR, EXT | 8'h12, 8'h3C, 2, 1'b1);
    xfer(ADDR, EXT | 8'h17, 8'hC0, 1, 1'b1);
    xfer(ADDR, EXT | 8'h24, 8'h77, 1, 1'b1);
    xfer(ADDR, 8'h10, 8'hEE, 1, 1'b1);
    t_hwload();
    noack(8'h9A);
    noack(8'h9D);
    noack(BCAST_ADDR | 8'h01);
    noack(8'h00);
    noack(8'hF0);
    t_partial();
    t_hs();
    xfer(ADDR, EXT | 8'h00, 8'h99, 1, 1'b1);
    xfer(BCAST_ADDR, 8'h30, 8'h00, 1, 1'b1);
    xfer(BCAST_ADDR, 8'h35, 8'h80, 1, 1'b1);
    print_verdict();
  end
endmodule : quad_dac_i2c_update_logic_tb_top
